// File: dcmp_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - each output is one when the selected positive input exceeds the selected negative input, readable and pinnable.
// - each comparator selects its positive input from two sources and its negative from a pin or the reference.
// - each comparator has a change flag in its configuration register set on any output change.
// - a set flag is readable by polling and requests an interrupt only when that interrupt is enabled.
// - both comparators share one interrupt request, and software reads both flags to find the source.
// - a disabled comparator has its output forced to one.
// - a low output forced high by disabling sets the flag and may interrupt.
// - comparators run on in idle and power-down but are disabled in total power-down.
// - outside total power-down an enabled change requests an interrupt and wakes the processor.
// - bit 5 of the auxiliary power control register switches both comparators off.
module dcmp_top
    import dcmp_pkg::*;
#(
    parameter int SETTLE_CYC = dcmp_pkg::DCMP_SETTLE_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // raw analog results per comparator, one per input pairing {psel,nsel}
    input  wire logic [3:0]  cmp0_raw,
    input  wire logic [3:0]  cmp1_raw,
    // analog side controls
    output logic      [1:0]  cmp_enable,
    output logic      [1:0]  pos_select,
    output logic      [1:0]  neg_select,
    output logic      [1:0]  settled,
    // pins and processor
    output logic      [1:0]  comparator_output_value,
    output logic      [1:0]  comparator_pin_oe,
    output logic             cmp_irq,
    output logic             cmp_wake
);
    import dcmp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire wr_en    = psel & penable & pwrite;
    wire hit_cfg0 = (paddr == DCMP_CFG0_OFF);
    wire hit_cfg1 = (paddr == DCMP_CFG1_OFF);
    wire hit_pwr  = (paddr == DCMP_PWR_OFF);
    wire hit_stat = (paddr == DCMP_STAT_OFF);
    wire hit_any  = hit_cfg0 | hit_cfg1 | hit_pwr | hit_stat;

    logic [4:0] cfg0_q, cfg1_q;       // en, psel, nsel, oe, ie
    logic [7:0] pwr_q;
    logic [1:0] flag_q;
    logic [1:0] co_q;
    logic [3:0] s0a_q, s0b_q, s1a_q, s1b_q;
    logic [1:0] prev_q;

    // single-cycle answer, unmapped addresses give an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    ////////////////////////////////////////////////////////////////////////////
    // power gating
    wire       tpd    = pwr_q[DCMP_TPD_BIT];
    wire       all_off = pwr_q[DCMP_OFF_BIT] | tpd;
    // idle and power-down leave comparators running; total power-down kills them
    assign cmp_enable = {cfg1_q[DCMP_EN_BIT], cfg0_q[DCMP_EN_BIT]} & {2{~all_off}};
    assign pos_select = {cfg1_q[DCMP_PSEL_BIT], cfg0_q[DCMP_PSEL_BIT]};
    assign neg_select = {cfg1_q[DCMP_NSEL_BIT], cfg0_q[DCMP_NSEL_BIT]};

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser; first stage read only by second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s0a_q <= 4'h0;
            s0b_q <= 4'h0;
            s1a_q <= 4'h0;
            s1b_q <= 4'h0;
        end else begin
            s0a_q <= cmp0_raw;
            s0b_q <= s0a_q;
            s1a_q <= cmp1_raw;
            s1b_q <= s1a_q;
        end
    end

    // pick the synchronised result of the selected input pairing
    wire [1:0] idx0 = {cfg0_q[DCMP_PSEL_BIT], cfg0_q[DCMP_NSEL_BIT]};
    wire [1:0] idx1 = {cfg1_q[DCMP_PSEL_BIT], cfg1_q[DCMP_NSEL_BIT]};
    wire       sel0 = s0b_q[idx0];
    wire       sel1 = s1b_q[idx1];
    // disabled comparator reads as one
    wire [1:0] co_d = {sel1 | ~cmp_enable[1], sel0 | ~cmp_enable[0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            co_q <= 2'b11;
        end else begin
            co_q <= co_d;
        end
    end
    assign comparator_output_value = co_q;
    assign comparator_pin_oe = {cfg1_q[DCMP_OE_BIT], cfg0_q[DCMP_OE_BIT]};

    ////////////////////////////////////////////////////////////////////////////
    // edge detect and sticky flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 2'b11;
        end else begin
            prev_q <= co_q;
        end
    end
    wire [1:0] change = prev_q ^ co_q;

    // clear by writing zero to the flag bit; a same-cycle change keeps it set
    wire [1:0] clr = {wr_en & hit_cfg1 & ~pwdata[DCMP_FLAG_BIT],
                      wr_en & hit_cfg0 & ~pwdata[DCMP_FLAG_BIT]};
    wire [1:0] flag_d = change | (flag_q & ~clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 2'b00;
        end else begin
            flag_q <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared interrupt and wake
    wire [1:0] ie  = {cfg1_q[DCMP_IE_BIT], cfg0_q[DCMP_IE_BIT]};
    assign cmp_irq  = |(flag_q & ie);
    assign cmp_wake = cmp_irq & ~tpd;

    ////////////////////////////////////////////////////////////////////////////
    // settle timers, status only; software owns the wait
    localparam int SW = $clog2(SETTLE_CYC + 1);
    logic [SW-1:0] cnt0_q, cnt1_q;
    wire  [SW-1:0] cnt_max = SW'(SETTLE_CYC);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt0_q <= '0;
            cnt1_q <= '0;
        end else begin
            cnt0_q <= !cmp_enable[0] ? '0 : (cnt0_q == cnt_max ? cnt0_q : cnt0_q + 1'b1);
            cnt1_q <= !cmp_enable[1] ? '0 : (cnt1_q == cnt_max ? cnt1_q : cnt1_q + 1'b1);
        end
    end
    assign settled = {cnt1_q == cnt_max, cnt0_q == cnt_max};

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg0_q <= DCMP_CFG_RST[4:0];
            cfg1_q <= DCMP_CFG_RST[4:0];
            pwr_q  <= DCMP_PWR_RST;
        end else begin
            if (wr_en && hit_cfg0) begin
                cfg0_q <= pwdata[4:0];
            end
            if (wr_en && hit_cfg1) begin
                cfg1_q <= pwdata[4:0];
            end
            if (wr_en && hit_pwr) begin
                pwr_q <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, registered data on each setup cycle
    wire [31:0] rd_cfg0 = {25'h0, flag_q[0], co_q[0], cfg0_q};
    wire [31:0] rd_cfg1 = {25'h0, flag_q[1], co_q[1], cfg1_q};
    wire [31:0] rd_pwr  = {24'h0, pwr_q};
    wire [31:0] rd_stat = {26'h0, settled, flag_q, co_q};
    wire [31:0] rd_mux  = hit_cfg0 ? rd_cfg0 :
                          hit_cfg1 ? rd_cfg1 :
                          hit_pwr  ? rd_pwr  :
                          hit_stat ? rd_stat : DCMP_ZERO;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= DCMP_ZERO;
        end else if (psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_force_high;
        @(posedge pclk) disable iff (!presetn)
        !cmp_enable[0] |=> comparator_output_value[0];
    endproperty
    a_force_high: assert property (p_force_high) else $error("disabled output not high");

    property p_flag_on_change;
        @(posedge pclk) disable iff (!presetn)
        $changed(comparator_output_value[0]) |=> flag_q[0];
    endproperty
    a_flag_on_change: assert property (p_flag_on_change) else $error("change did not set flag");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (change[0] && clr[0]) |=> flag_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat change");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        (flag_q[1] && !clr[1]) |=> flag_q[1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        cmp_irq |-> ((flag_q[0] && cfg0_q[DCMP_IE_BIT]) || (flag_q[1] && cfg1_q[DCMP_IE_BIT]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enabled flag");

    property p_tpd_off;
        @(posedge pclk) disable iff (!presetn)
        tpd |-> (cmp_enable == 2'b00) && !cmp_wake;
    endproperty
    a_tpd_off: assert property (p_tpd_off) else $error("active in total power-down");

    property p_pwr_off;
        @(posedge pclk) disable iff (!presetn)
        pwr_q[DCMP_OFF_BIT] |=> comparator_output_value == 2'b11;
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("power-off bit ignored");

    sequence s_raw_rise;
        cmp_enable[0] && idx0 == 2'b00 && $rose(cmp0_raw[0]);
    endsequence
    property p_sync_lat;
        @(posedge pclk) disable iff (!presetn)
        s_raw_rise ##1 (cmp_enable[0] && idx0 == 2'b00)[*2] |=> comparator_output_value[0];
    endproperty
    a_sync_lat: assert property (p_sync_lat) else $error("sync latency wrong");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        (cmp_irq && !tpd) |-> cmp_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on enabled change");

    ////////////////////////////////////////////////////////////////////////////
    // second comparator and the disable path; flags must follow the forced level too
    property p_force_high1;
        @(posedge pclk) disable iff (!presetn)
        !cmp_enable[1] |=> comparator_output_value[1];
    endproperty
    a_force_high1: assert property (p_force_high1) else $error("disabled output 1 not high");

    property p_flag_on_change1;
        @(posedge pclk) disable iff (!presetn)
        $changed(comparator_output_value[1]) |=> flag_q[1];
    endproperty
    a_flag_on_change1: assert property (p_flag_on_change1) else $error("change did not set flag 1");

    // a low output that loses its enable must still raise the flag, one edge after the forced output rises, as a live change does
    sequence s_low_running;
        cmp_enable[0] && !comparator_output_value[0];
    endsequence
    sequence s_low_stopped;
        !cmp_enable[0] && !comparator_output_value[0];
    endsequence
    property p_off_sets_flag;
        @(posedge pclk) disable iff (!presetn)
        s_low_running ##1 s_low_stopped |=> ##1 flag_q[0];
    endproperty
    a_off_sets_flag: assert property (p_off_sets_flag) else $error("disable did not set flag");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (clr[0] && !change[0]) |=> !flag_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("flag survived clear");

    property p_irq_shared;
        @(posedge pclk) disable iff (!presetn)
        (flag_q[1] && cfg1_q[DCMP_IE_BIT]) |-> cmp_irq;
    endproperty
    a_irq_shared: assert property (p_irq_shared) else $error("flag 1 missed shared request");

    // power control: the off bit clears both enables and total power-down parks the outputs high
    property p_off_enable;
        @(posedge pclk) disable iff (!presetn)
        pwr_q[DCMP_OFF_BIT] |-> (cmp_enable == 2'b00);
    endproperty
    a_off_enable: assert property (p_off_enable) else $error("comparator on while switched off");

    property p_tpd_high;
        @(posedge pclk) disable iff (!presetn)
        tpd |=> (comparator_output_value == 2'b11);
    endproperty
    a_tpd_high: assert property (p_tpd_high) else $error("output low in total power-down");
endmodule : dcmp_top

`default_nettype wire

// File: dcmp_pkg.sv
package dcmp_pkg;
    // register byte offsets
    localparam logic [11:0] DCMP_CFG0_OFF      = 12'h000;
    localparam logic [11:0] DCMP_CFG1_OFF      = 12'h004;
    localparam logic [11:0] DCMP_PWR_OFF       = 12'h008;
    localparam logic [11:0] DCMP_STAT_OFF      = 12'h00c;
    // configuration register fields
    localparam int          DCMP_EN_BIT        = 0;
    localparam int          DCMP_PSEL_BIT      = 1;
    localparam int          DCMP_NSEL_BIT      = 2;
    localparam int          DCMP_OE_BIT        = 3;
    localparam int          DCMP_IE_BIT        = 4;
    localparam int          DCMP_OUT_BIT       = 5;
    localparam int          DCMP_FLAG_BIT      = 6;
    // power control fields
    localparam int          DCMP_OFF_BIT       = 5;
    localparam int          DCMP_IDLE_BIT      = 0;
    localparam int          DCMP_PD_BIT        = 1;
    localparam int          DCMP_TPD_BIT       = 2;
    // reset values
    localparam logic [6:0]  DCMP_CFG_RST       = 7'h00;
    localparam logic [7:0]  DCMP_PWR_RST       = 8'h00;
    // settle time in ns and clock period
    localparam int          DCMP_SETTLE_NS     = 10000;
    localparam int          DCMP_CLK_NS        = 4;
    localparam int          DCMP_SETTLE_CYC    = DCMP_SETTLE_NS / DCMP_CLK_NS;
    localparam logic [31:0] DCMP_ZERO          = 32'h0000_0000;
endpackage : dcmp_pkg

// File: dcmp_ana_model.sv
`timescale 1ns/1ps
`default_nettype none

// behavioural comparator core: one raw result per input pairing
module dcmp_ana_model (
    // clock
    input  wire logic       pclk,
    // analog levels as codes
    input  wire logic [7:0] v_pos_a,
    input  wire logic [7:0] v_pos_b,
    input  wire logic [7:0] v_neg_pin,
    input  wire logic [7:0] v_ref,
    // results indexed {pos_sel,neg_sel}
    output logic      [3:0] raw
);
    // results change on the clock so the design sees clean levels
    always_ff @(posedge pclk) begin
        raw[0] <= v_pos_a > v_neg_pin;
        raw[1] <= v_pos_a > v_ref;
        raw[2] <= v_pos_b > v_neg_pin;
        raw[3] <= v_pos_b > v_ref;
    end
endmodule : dcmp_ana_model

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import dcmp_pkg::*;
    localparam int SC = 8; // short settle count keeps the run brief
    localparam logic [3:0] TBL1 = 4'b1011; // comparator 1 result per pairing {pos,neg}
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, cmp_irq, cmp_wake;
    logic [3:0]  raw0, raw1;
    logic [1:0]  cmp_enable, pos_select, neg_select, settled, comparator_output_value, comparator_pin_oe;
    logic [7:0]  va[2] = '{8'h64, 8'h64}, vb[2] = '{8'h14, 8'h14}, vn[2] = '{8'h3c, 8'h3c}, vref = 8'h0a;
    int          error_cnt = 0, n_compared = 0;

    always #2 pclk = ~pclk;

    dcmp_top #(.SETTLE_CYC(SC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp0_raw(raw0), .cmp1_raw(raw1), .cmp_enable(cmp_enable), .pos_select(pos_select),
        .neg_select(neg_select), .settled(settled), .comparator_output_value(comparator_output_value),
        .comparator_pin_oe(comparator_pin_oe), .cmp_irq(cmp_irq), .cmp_wake(cmp_wake));
    dcmp_ana_model ana0 (.pclk(pclk), .v_pos_a(va[0]), .v_pos_b(vb[0]), .v_neg_pin(vn[0]), .v_ref(vref), .raw(raw0));
    dcmp_ana_model ana1 (.pclk(pclk), .v_pos_a(va[1]), .v_pos_b(vb[1]), .v_neg_pin(vn[1]), .v_ref(vref), .raw(raw1));

    ////////////////////////////////////////////////////////////////////////
    task conclude;
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    task tmo;
        $display("BAD %0t wait ran out", $time);
        error_cnt++;
        conclude();
    endtask : tmo

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; ends at the falling edge so outputs have settled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) tmo();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask : rdc

    // output takes a few edges through the synchroniser
    task wait_out(input int i, input logic v);
        int n;
        n = 0;
        while (comparator_output_value[i] !== v && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (comparator_output_value[i] !== v) tmo();
        @(negedge pclk);
    endtask : wait_out

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(DCMP_CFG0_OFF, 32'hffffffff, 32'h20);
        rdc(DCMP_PWR_OFF, 32'hffffffff, 32'h0);
        rdc(DCMP_STAT_OFF, 32'hffffffff, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, DCMP_CFG0_OFF, 32'h49);
        chk({28'h0, cmp_enable, comparator_pin_oe}, 32'h5);
        chk({30'h0, settled}, 32'h0);
        repeat (SC + 2) @(posedge pclk);
        chk({30'h0, settled}, 32'h1);
        apb(1'b1, DCMP_CFG0_OFF, 32'h09);
        rdc(DCMP_CFG0_OFF, 32'h7f, 32'h29);
        va[0] <= 8'h0a;
        wait_out(0, 1'b0);
        rdc(DCMP_CFG0_OFF, 32'h7f, 32'h49);
        chk({31'h0, cmp_irq}, 32'h0);
        apb(1'b1, DCMP_CFG0_OFF, 32'h59);
        chk({30'h0, cmp_irq, cmp_wake}, 32'h3);
        apb(1'b1, DCMP_PWR_OFF, 32'h3);
        chk({30'h0, cmp_enable}, 32'h1);
        chk({30'h0, comparator_pin_oe}, 32'h1);
        apb(1'b1, DCMP_CFG0_OFF, 32'h19);
        rdc(DCMP_CFG0_OFF, 32'h7f, 32'h19);
        chk({31'h0, cmp_irq}, 32'h0);
        va[0] <= 8'h64;
        wait_out(0, 1'b1);
        rdc(DCMP_CFG0_OFF, 32'h7f, 32'h79);
        // the clear write lands on the edge where the falling output is detected
        va[0] <= 8'h0a;
        repeat (2) @(posedge pclk);
        apb(1'b1, DCMP_CFG0_OFF, 32'h19);
        rdc(DCMP_CFG0_OFF, 32'h7f, 32'h59);
        apb(1'b1, DCMP_CFG0_OFF, 32'h19);
        apb(1'b1, DCMP_CFG0_OFF, 32'h18);
        wait_out(0, 1'b1);
        rdc(DCMP_CFG0_OFF, 32'h7f, 32'h78);
        chk({31'h0, cmp_irq}, 32'h1);
        apb(1'b1, DCMP_CFG0_OFF, 32'h18);
        chk({31'h0, cmp_irq}, 32'h0);
        // every pairing of comparator 1 against the table 1,1,0,1
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, DCMP_CFG1_OFF, 32'h41 | (k[1] << 1) | (k[0] << 2));
            chk({30'h0, pos_select[1], neg_select[1]}, k);
            wait_out(1, TBL1[k]);
        end
        apb(1'b1, DCMP_CFG1_OFF, 32'h57);
        chk({31'h0, cmp_irq}, 32'h1);
        rdc(DCMP_STAT_OFF, 32'hf, 32'hb);
        apb(1'b1, DCMP_PWR_OFF, 32'h20);
        chk({28'h0, cmp_enable, comparator_output_value}, 32'h3);
        apb(1'b1, DCMP_PWR_OFF, 32'h4);
        chk({28'h0, cmp_enable, cmp_irq, cmp_wake}, 32'h2);
        rdc(DCMP_PWR_OFF, 32'hff, 32'h4);
        apb(1'b1, DCMP_PWR_OFF, 32'h0);
        chk({30'h0, cmp_enable}, 32'h2);
        conclude();
    end
endmodule : testbench

`default_nettype wire
